// ===== fpt_pkg.sv
// constants for the flyback pwm timing block
// assumes a 25 MHz core clock and millivolt-coded feedback from an adc
package fpt_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int SS_TIME_MS = 12;
    localparam int SS_CYCLES = SS_TIME_MS * (CLK_HZ / 1000);
    localparam int SS_STEPS = 4;
    localparam int JIT_TIME_MS = 4;
    localparam int JIT_CYCLES = JIT_TIME_MS * (CLK_HZ / 1000);
    localparam int NOM_FREQ_HZ = 100_000;
    localparam int MIN_FREQ_HZ = 25_000;
    localparam logic [9:0] NOM_PERIOD = 10'(CLK_HZ / NOM_FREQ_HZ);
    localparam logic [9:0] MAX_PERIOD = 10'(CLK_HZ / MIN_FREQ_HZ);
    localparam logic [9:0] JIT_AMP = 10'((CLK_HZ / NOM_FREQ_HZ) * 4 / 100);
    localparam int LEB_TIME_NS = 300;
    localparam logic [9:0] LEB_CYC = 10'((LEB_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    localparam logic [11:0] FB_KNEE_MV = 12'h6a4;
    localparam logic [9:0] SS_LIMIT_MV_0 = 10'h12c;
    localparam logic [9:0] SS_LIMIT_MV_1 = 10'h1d3;
    localparam logic [9:0] SS_LIMIT_MV_2 = 10'h279;
    localparam logic [9:0] NORMAL_PEAK_LIMIT_MV = 10'h320;

    typedef enum logic [1:0] {
        FPT_IDLE = 2'b00,
        FPT_SOFT = 2'b01,
        FPT_RUN = 2'b10
    } fpt_state_e;
endpackage : fpt_pkg

// ===== fpt_flyback_pwm.sv
// switching-cycle timing: soft-start, gate on/off, frequency reduction,
// jitter and slope-compensation window
// assumes comparators and supply detector are asynchronous analog outputs
`timescale 1ns/100ps

module fpt_flyback_pwm #(
    parameter int P_SS_CYCLES = fpt_pkg::SS_CYCLES,
    parameter int P_JIT_CYCLES = fpt_pkg::JIT_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_supply_ok,
    input wire logic i_pwm_cmp,
    input wire logic i_peak_cmp,
    input wire logic i_regulated,
    input wire logic [11:0] i_feedback_voltage,
    input wire logic i_burst_mode,
    output logic o_gate,
    output logic [9:0] o_peak_limit_mv,
    output logic [9:0] o_period,
    output logic o_slope_comp_en,
    output logic [9:0] o_slope_ramp,
    output logic o_jitter_en,
    output logic o_softstart_done
);
    localparam logic [31:0] SS_STEP_LEN = 32'(P_SS_CYCLES / fpt_pkg::SS_STEPS);
    localparam logic [31:0] JIT_STEP_LEN = 32'(P_JIT_CYCLES / (4 * fpt_pkg::JIT_AMP));

    function automatic logic [9:0] ss_limit(input logic [1:0] step);
        case (step)
            2'h0: ss_limit = fpt_pkg::SS_LIMIT_MV_0;
            2'h1: ss_limit = fpt_pkg::SS_LIMIT_MV_1;
            2'h2: ss_limit = fpt_pkg::SS_LIMIT_MV_2;
            default: ss_limit = fpt_pkg::NORMAL_PEAK_LIMIT_MV;
        endcase
    endfunction : ss_limit

    function automatic logic [9:0] duty_end(input logic [9:0] per);
        duty_end = 10'((12'(per) * 12'h003) >> 2);
    endfunction : duty_end

    function automatic logic [9:0] slope_start(input logic [9:0] per);
        slope_start = 10'((12'(per) * 12'h002) / 12'h005);
    endfunction : slope_start

    // two-stage synchronisers; stage one feeds nothing but stage two
    logic [3:0] sync1;
    logic [3:0] sync2;
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {i_regulated, i_peak_cmp, i_pwm_cmp, i_supply_ok};
            sync2 <= sync1;
        end
    end
    logic supply_s;
    logic pwm_s;
    logic peak_s;
    logic reg_s;
    assign supply_s = sync2[0];
    assign pwm_s = sync2[1];
    assign peak_s = sync2[2];
    assign reg_s = sync2[3];

    // sequencing state
    fpt_pkg::fpt_state_e state;
    fpt_pkg::fpt_state_e next_state;
    logic [31:0] ss_tick;
    logic [31:0] next_ss_tick;
    logic [1:0] ss_step;
    logic [1:0] next_ss_step;

    always_comb begin
        next_state = state;
        next_ss_tick = ss_tick;
        next_ss_step = ss_step;
        case (state)
            fpt_pkg::FPT_IDLE: begin
                next_ss_tick = 32'h0;
                next_ss_step = 2'h0;
                if (supply_s) begin
                    next_state = fpt_pkg::FPT_SOFT;
                end
            end
            fpt_pkg::FPT_SOFT: begin
                if (reg_s) begin
                    next_state = fpt_pkg::FPT_RUN;
                end else if (ss_tick == SS_STEP_LEN - 32'h1) begin
                    next_ss_tick = 32'h0;
                    if (ss_step == 2'h3) begin
                        next_state = fpt_pkg::FPT_RUN;
                    end else begin
                        next_ss_step = ss_step + 2'h1;
                    end
                end else begin
                    next_ss_tick = ss_tick + 32'h1;
                end
            end
            fpt_pkg::FPT_RUN: begin
                next_ss_tick = 32'h0;
            end
            default: begin
                next_state = fpt_pkg::FPT_IDLE;
            end
        endcase
        // a supply drop aborts everything, including the soft-start
        if (!supply_s) begin
            next_state = fpt_pkg::FPT_IDLE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state <= fpt_pkg::FPT_IDLE;
            ss_tick <= 32'h0;
            ss_step <= 2'h0;
        end else begin
            state <= next_state;
            ss_tick <= next_ss_tick;
            ss_step <= next_ss_step;
        end
    end

    // jitter: triangle sweep of the period, 0..2*amp around nominal
    logic [31:0] jit_tick;
    logic [31:0] next_jit_tick;
    logic [9:0] jit_ofs;
    logic [9:0] next_jit_ofs;
    logic jit_up;
    logic next_jit_up;
    logic jit_run;
    assign jit_run = (state == fpt_pkg::FPT_RUN);

    always_comb begin
        next_jit_tick = jit_tick;
        next_jit_ofs = jit_ofs;
        next_jit_up = jit_up;
        if (!jit_run) begin
            next_jit_tick = 32'h0;
            next_jit_ofs = fpt_pkg::JIT_AMP;
            next_jit_up = 1'b1;
        end else if (jit_tick == JIT_STEP_LEN - 32'h1) begin
            next_jit_tick = 32'h0;
            if (jit_up) begin
                next_jit_ofs = jit_ofs + 10'h1;
                next_jit_up = (jit_ofs + 10'h1) != (fpt_pkg::JIT_AMP << 1);
            end else begin
                next_jit_ofs = jit_ofs - 10'h1;
                next_jit_up = (jit_ofs == 10'h1);
            end
        end else begin
            next_jit_tick = jit_tick + 32'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            jit_tick <= 32'h0;
            jit_ofs <= fpt_pkg::JIT_AMP;
            jit_up <= 1'b1;
        end else begin
            jit_tick <= next_jit_tick;
            jit_ofs <= next_jit_ofs;
            jit_up <= next_jit_up;
        end
    end

    // period choice from feedback; the floor clamps before jitter is added
    logic [11:0] fb_deficit;
    logic [10:0] base_period;
    logic [9:0] new_period;
    always_comb begin
        fb_deficit = 12'h0;
        if (i_feedback_voltage < fpt_pkg::FB_KNEE_MV) begin
            fb_deficit = fpt_pkg::FB_KNEE_MV - i_feedback_voltage;
        end
        base_period = 11'(fpt_pkg::NOM_PERIOD) + 11'(fb_deficit[11:1]);
        if (base_period > 11'(fpt_pkg::MAX_PERIOD)) begin
            base_period = 11'(fpt_pkg::MAX_PERIOD);
        end
        new_period = base_period[9:0] + jit_ofs - fpt_pkg::JIT_AMP;
    end

    // switching cycle
    logic [9:0] cyc_cnt;
    logic [9:0] next_cyc_cnt;
    logic [9:0] next_period;
    logic next_gate;
    logic next_slope_en;
    logic [9:0] next_slope_ramp;
    logic cycle_wrap;
    logic cmp_off;
    logic running;

    assign running = (state != fpt_pkg::FPT_IDLE);
    assign cycle_wrap = (cyc_cnt >= o_period - 10'h1);

    always_comb begin
        next_cyc_cnt = cyc_cnt + 10'h1;
        next_period = o_period;
        next_gate = o_gate;
        // comparator only looked at once blanking has elapsed
        cmp_off = (pwm_s || peak_s) && (cyc_cnt >= fpt_pkg::LEB_CYC);
        if (cycle_wrap) begin
            next_cyc_cnt = 10'h0;
            next_period = new_period;
            next_gate = running;
        end else if (!running || cmp_off || cyc_cnt >= duty_end(o_period)) begin
            next_gate = 1'b0;
        end
        next_slope_en = next_gate && !i_burst_mode
            && (next_cyc_cnt >= slope_start(next_period));
        next_slope_ramp = 10'h0;
        if (next_slope_en) begin
            next_slope_ramp = next_cyc_cnt - slope_start(next_period);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cyc_cnt <= 10'h0;
            o_period <= fpt_pkg::NOM_PERIOD;
            o_gate <= 1'b0;
            o_slope_comp_en <= 1'b0;
            o_slope_ramp <= 10'h0;
        end else begin
            cyc_cnt <= next_cyc_cnt;
            o_period <= next_period;
            o_gate <= next_gate;
            o_slope_comp_en <= next_slope_en;
            o_slope_ramp <= next_slope_ramp;
        end
    end

    // limit: stepped in soft-start, normal once the loop has taken over
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_peak_limit_mv <= fpt_pkg::SS_LIMIT_MV_0;
            o_jitter_en <= 1'b0;
            o_softstart_done <= 1'b0;
        end else begin
            o_peak_limit_mv <= (next_state == fpt_pkg::FPT_RUN)
                ? fpt_pkg::NORMAL_PEAK_LIMIT_MV : ss_limit(next_ss_step);
            o_jitter_en <= (next_state == fpt_pkg::FPT_RUN);
            o_softstart_done <= (next_state == fpt_pkg::FPT_RUN);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    sequence s_gate_rise;
        !o_gate ##1 o_gate;
    endsequence

    AST_NO_GATE_IDLE: assert property (
        (state == fpt_pkg::FPT_IDLE) |=> !o_gate)
        else $error("gate on without supply");
    AST_IDLE_TO_SOFT: assert property (
        (state == fpt_pkg::FPT_IDLE && supply_s) |=> state == fpt_pkg::FPT_SOFT)
        else $error("soft-start not entered");
    AST_SS_STEP: assert property (
        (state == fpt_pkg::FPT_SOFT && supply_s && !reg_s && ss_step != 2'h3
            && ss_tick == SS_STEP_LEN - 32'h1) |=> ss_step == $past(ss_step) + 2'h1)
        else $error("soft-start step not advanced");
    AST_SS_LIMIT: assert property (
        (state == fpt_pkg::FPT_SOFT) |-> o_peak_limit_mv == ss_limit(ss_step))
        else $error("soft-start limit wrong");
    AST_REG_TAKEOVER: assert property (
        (state == fpt_pkg::FPT_SOFT && reg_s && supply_s) |=> o_softstart_done
            && o_peak_limit_mv == fpt_pkg::NORMAL_PEAK_LIMIT_MV)
        else $error("feedback loop did not take over");
    AST_SYNC_ON: assert property (
        s_gate_rise |-> cyc_cnt == 10'h0)
        else $error("gate on out of step with oscillator");
    AST_LEB_MIN_ON: assert property (
        s_gate_rise |-> o_gate [*8])
        else $error("on-time shorter than blanking");
    AST_PWM_OFF: assert property (
        (o_gate && pwm_s && cyc_cnt >= fpt_pkg::LEB_CYC && !cycle_wrap) |=> !o_gate)
        else $error("gate stayed on after comparator");
    AST_MAX_DUTY: assert property (
        o_gate |-> cyc_cnt <= duty_end(o_period) + 10'h1)
        else $error("duty limit exceeded");
    AST_FLOOR: assert property (
        o_period <= fpt_pkg::MAX_PERIOD + fpt_pkg::JIT_AMP)
        else $error("period beyond frequency floor");
    AST_NOMINAL: assert property (
        (cycle_wrap && !jit_run && i_feedback_voltage >= fpt_pkg::FB_KNEE_MV)
            |=> o_period == fpt_pkg::NOM_PERIOD)
        else $error("frequency reduced at high load");
    AST_SLOPE_WIN: assert property (
        o_slope_comp_en |-> o_gate && !$past(i_burst_mode)
            && cyc_cnt >= slope_start(o_period))
        else $error("slope compensation outside window");
    AST_JITTER: assert property (
        (state != fpt_pkg::FPT_RUN) |-> jit_ofs == fpt_pkg::JIT_AMP || $past(jit_run))
        else $error("jitter active before soft-start end");
endmodule : fpt_flyback_pwm

// ===== fpt_analog_model.sv
// behavioural comparators of the flyback sense path
// assumes the gate output is the only stimulus of the current ramp
`timescale 1ns/100ps

module fpt_analog_model (
    input wire logic i_core_clk,
    input wire logic i_gate,
    input wire integer i_pwm_trip,
    input wire integer i_peak_trip,
    output logic o_pwm_cmp,
    output logic o_peak_cmp
);
    int ramp = 0;

    // ramp restarts with each gate pulse, so both comparators fall with the gate
    always @(posedge i_core_clk) begin
        ramp <= i_gate ? ramp + 1 : 0;
    end

    always @(*) begin
        o_pwm_cmp = i_gate && (ramp >= i_pwm_trip);
        o_peak_cmp = i_gate && (ramp >= i_peak_trip);
    end
endmodule : fpt_analog_model

// ===== fpt_flyback_pwm_tb_top.sv
// self-checking bench for the flyback pwm timing block
// assumes shortened soft-start and jitter counts of 400 cycles
`timescale 1ns/100ps

module fpt_flyback_pwm_tb_top;
    localparam int SS = 400;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic supply = 1'b0;
    logic regulated = 1'b0;
    logic burst = 1'b0;
    logic [11:0] fb = 12'h7d0;
    logic pwm_cmp, peak_cmp, gate, slope_en, jit_en, done;
    logic [9:0] limit, period, ramp;
    int pwm_trip = 1000;
    int peak_trip = 1000;
    int fails = 0;
    int n_tests = 0;
    int seed = 45;
    int on_n = 0, sl_n = 0, per_n = 0, last_per = 0, skip = 2;
    bit mon = 0;
    bit prev = 0;

    always #20 clk = ~clk;

    fpt_flyback_pwm #(.P_SS_CYCLES(SS), .P_JIT_CYCLES(400)) fpt_flyback_pwm_i (
        .i_core_clk(clk), .i_srst(srst), .i_supply_ok(supply), .i_pwm_cmp(pwm_cmp),
        .i_peak_cmp(peak_cmp), .i_regulated(regulated), .i_feedback_voltage(fb),
        .i_burst_mode(burst), .o_gate(gate), .o_peak_limit_mv(limit), .o_period(period),
        .o_slope_comp_en(slope_en), .o_slope_ramp(ramp), .o_jitter_en(jit_en),
        .o_softstart_done(done)
    );

    fpt_analog_model fpt_analog_model_i (
        .i_core_clk(clk), .i_gate(gate), .i_pwm_trip(pwm_trip), .i_peak_trip(peak_trip),
        .o_pwm_cmp(pwm_cmp), .o_peak_cmp(peak_cmp)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk

    // tol cycles of slack either side; 1 absorbs the synchroniser edge uncertainty
    task automatic near(input string what, input logic [31:0] seen, input int exp, input int tol);
        bit ok;
        ok = (seen >= exp - tol) && (seen <= exp + tol);
        chk(what, ok ? exp : seen, exp);
    endtask : near

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc

    task automatic final_report();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // reference model of each pulse: on-time, slope window and spacing
    always @(posedge clk) begin
        int trip, exp_on, st;
        if (gate === 1'b1 && !prev) begin
            if (mon && skip == 0)
                chk("period spacing", per_n, last_per);
            last_per = int'(period);
            per_n = 0;
        end
        if (gate !== 1'b1 && prev) begin
            trip = (pwm_trip < peak_trip) ? pwm_trip : peak_trip;
            exp_on = (trip + 3 > 9) ? trip + 3 : 9;
            if (exp_on > ((last_per * 3) >> 2) + 1)
                exp_on = ((last_per * 3) >> 2) + 1;
            st = (last_per * 2) / 5;
            if (mon && skip == 0) begin
                near("on time", on_n, exp_on, 1);
                near("slope cycles", sl_n, (burst || exp_on <= st) ? 0 : exp_on - st, 1);
            end
            if (skip > 0)
                skip--;
            on_n = 0;
            sl_n = 0;
        end
        if (gate === 1'b1)
            on_n++;
        if (slope_en === 1'b1) begin
            if (mon && skip == 0)
                chk("ramp value", ramp, sl_n);
            sl_n++;
        end
        if (mon && slope_en !== 1'b1)
            chk("ramp idle", ramp, 0);
        per_n++;
        prev = (gate === 1'b1);
    end

    task automatic set_link(input int pt, input int kt, input logic b, input logic [11:0] f);
        pwm_trip = pt;
        peak_trip = kt;
        burst = b;
        fb = f;
        skip = 2;
        cyc(6 * 1010);
    endtask : set_link

    initial begin
        int trips[4];
        logic [11:0] fbs[8];
        int base;
        trips = '{0, 5, 20, 1000};
        fbs = '{12'h6a4, 12'h6a3, 12'h3e8, 12'h000, 12'hfff, 12'h0, 12'h0, 12'h0};
        for (int i = 5; i < 8; i++)
            fbs[i] = 12'($unsigned($random(seed)) % 2000);
        cyc(6);
        srst = 1'b0;
        chk("reset limit", limit, fpt_pkg::SS_LIMIT_MV_0);
        chk("reset period", period, fpt_pkg::NOM_PERIOD);
        chk("reset done", done, 0);
        cyc(50);
        chk("gate before supply", gate, 0);
        supply = 1'b1;
        cyc(50);
        chk("step 0", limit, fpt_pkg::SS_LIMIT_MV_0);
        cyc(100);
        chk("step 1", limit, fpt_pkg::SS_LIMIT_MV_1);
        cyc(100);
        chk("step 2", limit, fpt_pkg::SS_LIMIT_MV_2);
        cyc(100);
        chk("step 3", limit, fpt_pkg::NORMAL_PEAK_LIMIT_MV);
        chk("jitter in soft", jit_en, 0);
        cyc(70);
        chk("soft done", done, 1);
        chk("jitter on", jit_en, 1);
        mon = 1;
        foreach (trips[i])
            set_link(trips[i], 1000, 1'b0, 12'h7d0);
        set_link(1000, 30, 1'b0, 12'h7d0);
        set_link(1000, 1000, 1'b1, 12'h7d0);
        foreach (fbs[i]) begin
            set_link(2, 1000, 1'b0, fbs[i]);
            base = (fbs[i] >= 1700) ? 250 : 250 + (1700 - int'(fbs[i])) / 2;
            base = (base > 1000) ? 1000 : base;
            near("period vs fb", period, base, 10);
        end
        mon = 0;
        // long pulse so the supply drop has a gate to cut
        pwm_trip = 1000;
        srst = 1'b1;
        cyc(6);
        srst = 1'b0;
        cyc(280);
        regulated = 1'b1;
        cyc(5);
        chk("early done", done, 1);
        chk("run limit", limit, fpt_pkg::NORMAL_PEAK_LIMIT_MV);
        chk("gate before drop", gate, 1);
        supply = 1'b0;
        cyc(5);
        chk("gate after drop", gate, 0);
        chk("done after drop", done, 0);
        final_report();
    end

    // whole run is about 86k cycles; limit leaves some margin
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule : fpt_flyback_pwm_tb_top
